// File: hdl/mpi_pkg.sv
// constants and carrier types of the phy data interface
package mpi_pkg;

    // ----------
    // clock rates
    // ----------
    localparam int unsigned CLK_HZ  = 250_000_000;
    localparam int unsigned F100_HZ = 25_000_000;
    localparam int unsigned F10_HZ  = 2_500_000;
    localparam int unsigned FREF_HZ = 50_000_000;

    // reduced interface: ref ticks per dibit at each speed
    localparam logic [3:0] REP100 = 4'h1;
    localparam logic [3:0] REP10  = 4'hA;

    // ----------
    // straps and registers
    // ----------
    localparam logic [2:0] STRAP_RMII = 3'h1;
    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_PHYCTL = 6'h1F;
    localparam logic [5:0] IDX_LNKCTL = 6'h20;
    localparam logic [5:0] IDX_STAT   = 6'h21;
    localparam int unsigned REF50_BIT = 7;
    localparam int unsigned SPD_BIT   = 0;
    localparam int unsigned EEE_BIT   = 1;
    localparam int unsigned HDX_BIT   = 2;
    localparam logic [2:0] LNK_RST    = 3'h1;

    // ----------
    // line codes
    // ----------
    localparam logic [3:0] NIB_IDLE = 4'h0;
    localparam logic [3:0] NIB_LPI  = 4'h1;
    localparam logic [3:0] NIB_LPI2 = 4'h5;
    localparam logic [3:0] SFD_LO   = 4'h5;
    localparam logic [3:0] SFD_HI   = 4'hD;
    localparam logic [1:0] DIB_LPI  = 2'h1;

    // line receiver towards the interface, pclk domain
    typedef struct packed {
        logic       carrier;
        logic       link;
        logic       sos;
        logic       eos;
        logic       idle;
        logic       lpi;
        logic       rec_edge;
        logic       vld;
        logic       err;
        logic [3:0] nib;
    } mpi_line_rx_type;

    // interface towards the line transmitter
    typedef struct packed {
        logic       active;
        logic       lpi;
        logic       vld;
        logic [3:0] nib;
    } mpi_line_tx_type;

endpackage : mpi_pkg

// File: hdl/mpi_phy_data_if.sv
// phy-side mii / rmii data interface with apb control
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ns

// Functional notes
// - device sources txc, 2.5 or 25 MHz
// - txen high takes one nibble per txc
// - txer means lpi only in eee mode
// - rxc recovered or local, by speed
// - 10M rxdv rises on sfd nibble 5
// - 100M rxdv covers preamble to last nibble
// - rxd idle 0000, lpi 0001 when rxdv low
// - rxer flags symbol errors during rxdv
// - eee rxer with rxdv low signals lpi
// - 10M crs: preamble up, eof down
// - 100M crs: j/k up, t/r or idle down
// - half duplex collision, unsynchronised output
// - strap 001 selects rmii, bit7 ref mode
// - rmii times everything on 50MHz reference
// - 25MHz mode drives ref out, else input
// - crs_dv rises asynchronously on carrier
// - crs_dv spans frame, rxd 00 until decoded
// - crs_dv low gives rxd 00 or 01
module mpi_phy_data_if #(
    parameter int unsigned CLK_HZ = mpi_pkg::CLK_HZ
) (
    // clock, reset, enable
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     ce,
    // apb slave
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [11:0]              paddr,
    input  wire logic [31:0]              pwdata,
    output logic [31:0]                   prdata,
    output logic                          pready,
    output logic                          pslverr,
    // straps and reference clock pins
    input  wire logic [2:0]               cfg_strap,
    input  wire logic                     crystal_input,
    output logic                          ref_clk_out,
    output logic                          ref_clk_oe_n,
    // mac-facing transmit pins
    output logic                          phy_txc,
    input  wire logic                     phy_txen,
    input  wire logic [3:0]               phy_txd,
    input  wire logic                     phy_txer,
    // mac-facing receive pins
    output logic                          phy_rxc,
    output logic                          phy_rxdv,
    output logic [3:0]                    phy_rxd,
    output logic                          phy_rxer,
    output logic                          phy_crs,
    output logic                          phy_col,
    // line side
    input  wire mpi_pkg::mpi_line_rx_type line_rx,
    output mpi_pkg::mpi_line_tx_type      line_tx
);
    import mpi_pkg::*;

    // ----------
    // derived counts
    // ----------
    localparam logic [7:0] H100  = 8'(CLK_HZ / (2 * F100_HZ));
    localparam logic [7:0] H10   = 8'(CLK_HZ / (2 * F10_HZ));
    localparam logic [7:0] REFD  = 8'(CLK_HZ / FREF_HZ);
    localparam logic [7:0] REFHI = 8'(CLK_HZ / FREF_HZ / 2);

    // dividers must be whole and fit the 8-bit counters
    if (CLK_HZ % (2 * F100_HZ) != 0 || CLK_HZ % FREF_HZ != 0
        || CLK_HZ / (2 * F10_HZ) > 255 || CLK_HZ / FREF_HZ < 2) begin : g_bad_clk
        $error("mpi_phy_data_if: unusable CLK_HZ");
    end

    // ----------
    // state
    // ----------
    logic        ref50_r, spd100_r, eee_r, hdx_r, strap_done_r, rmii_r;
    logic [6:0]  s1_r, s2_r, s3_r, pin_r;
    logic        xi_prev_r, refo_r, txc_r, rxc_r, tph_r, tvld_r, tlpi_r, tact_r;
    logic        rph_r, p_vld_r, p_err_r, rxdv_r, rxer_r, crs_r;
    logic [3:0]  dcnt_r, tnib_r, p_nib_r, rxd_r;
    logic [7:0]  refc_r, tcnt_r, rcnt_r;
    logic [1:0]  tlo_r, rhi_r;
    logic [31:0] prdata_r;

    // ----------
    // apb decode
    // ----------
    logic [5:0]  idx;
    logic        in_page, hit_phy, hit_lnk, hit_st, hit, wr;
    logic [31:0] rdata;

    assign idx     = paddr[7:2];
    assign in_page = (paddr[11:8] == 4'h0) && (paddr[1:0] == 2'h0);
    assign hit_phy = in_page && (idx == IDX_PHYCTL);
    assign hit_lnk = in_page && (idx == IDX_LNKCTL);
    assign hit_st  = in_page && (idx == IDX_STAT);
    assign hit     = hit_phy | hit_lnk | hit_st;
    assign wr      = psel & penable & pwrite & hit;
    // zero wait states; read data is loaded during setup
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit;
    assign prdata  = prdata_r;

    // read mux; unlisted bits read as zero
    assign rdata = hit_phy ? {24'h00_0000, ref50_r, 7'h00} :
                   hit_lnk ? {29'h0000_0000, hdx_r, eee_r, spd100_r} :
                   hit_st  ? {25'h000_0000, rmii_r, tlpi_r, tact_r,
                              crs_r, rxdv_r, rxer_r, phy_col} :
                             32'h0000_0000;

    // control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref50_r  <= 1'b0;
            spd100_r <= LNK_RST[SPD_BIT];
            eee_r    <= LNK_RST[EEE_BIT];
            hdx_r    <= LNK_RST[HDX_BIT];
            prdata_r <= 32'h0000_0000;
        end else if (ce) begin
            if (wr && hit_phy)
                ref50_r <= pwdata[REF50_BIT];
            if (wr && hit_lnk) begin
                spd100_r <= pwdata[SPD_BIT];
                eee_r    <= pwdata[EEE_BIT];
                hdx_r    <= pwdata[HDX_BIT];
            end
            if (psel && !penable)
                prdata_r <= pwrite ? 32'h0000_0000 : rdata;
        end
    end

    // strap caught once, first enabled cycle after reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_done_r <= 1'b0;
            rmii_r       <= 1'b0;
        end else if (ce && !strap_done_r) begin
            strap_done_r <= 1'b1;
            rmii_r       <= (cfg_strap == STRAP_RMII);
        end
    end

    // ----------
    // pin synchronisers
    // ----------
    // a bit moves once stages two and three agree: one mid-edge sample is filtered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r  <= 7'h00;
            s2_r  <= 7'h00;
            s3_r  <= 7'h00;
            pin_r <= 7'h00;
        end else if (ce) begin
            s1_r  <= {phy_txen, phy_txd, phy_txer, crystal_input};
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            pin_r <= (s2_r & s3_r) | (pin_r & (s2_r | s3_r));
        end
    end

    logic       txen, txer, xi;
    logic [3:0] txd;

    assign txen = pin_r[6];
    assign txd  = pin_r[5:2];
    assign txer = pin_r[1];
    assign xi   = pin_r[0];

    // ----------
    // reference clock
    // ----------
    logic       ref_wrap, ref_tick, drive_ref, dtick;
    logic [3:0] rep;

    assign ref_wrap  = (refc_r >= REFD - 8'h01);
    // 50MHz mode follows the crystal input, else the local divider
    assign ref_tick  = ref50_r ? (xi & ~xi_prev_r) : ref_wrap;
    assign drive_ref = rmii_r & ~ref50_r;
    assign ref_clk_out  = refo_r;
    assign ref_clk_oe_n = ~drive_ref;
    assign rep   = spd100_r ? REP100 : REP10;
    assign dtick = ref_tick & (dcnt_r == 4'h0);

    // 50MHz synthesised from pclk; pin is left undriven in 50MHz mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            refc_r    <= 8'h00;
            refo_r    <= 1'b0;
            xi_prev_r <= 1'b0;
            dcnt_r    <= 4'h0;
        end else if (ce) begin
            refc_r    <= ref_wrap ? 8'h00 : refc_r + 8'h01;
            refo_r    <= drive_ref & (ref_wrap | (refc_r < REFHI - 8'h01));
            xi_prev_r <= xi;
            if (ref_tick)
                dcnt_r <= (dcnt_r >= rep - 4'h1) ? 4'h0 : dcnt_r + 4'h1;
        end
    end

    // ----------
    // mii clocks
    // ----------
    logic [7:0] half;
    logic       tc_wrap, rc_wrap, rec_use, tx_tick, rx_tick;

    assign half    = spd100_r ? H100 : H10;
    assign tc_wrap = (tcnt_r >= half - 8'h01);
    assign rc_wrap = (rcnt_r >= half - 8'h01);
    // recovered timing: whenever link is up at 100M, only under carrier at 10M
    assign rec_use = spd100_r ? line_rx.link : line_rx.carrier;
    assign tx_tick = rmii_r ? dtick : (tc_wrap & ~txc_r);
    assign rx_tick = rmii_r ? dtick : (rc_wrap & ~rxc_r);
    assign phy_txc = txc_r & ~rmii_r;
    assign phy_rxc = rxc_r & ~rmii_r;

    // txc never stops: the mac times txen and txd on it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tcnt_r <= 8'h00;
            txc_r  <= 1'b0;
        end else if (ce) begin
            tcnt_r <= tc_wrap ? 8'h00 : tcnt_r + 8'h01;
            if (tc_wrap)
                txc_r <= ~txc_r;
        end
    end

    // rxc runs locally, re-phased on each recovered line edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rcnt_r <= 8'h00;
            rxc_r  <= 1'b0;
        end else if (ce) begin
            if (rec_use && line_rx.rec_edge)
                rcnt_r <= 8'h00;
            else
                rcnt_r <= rc_wrap ? 8'h00 : rcnt_r + 8'h01;
            if (rc_wrap && !(rec_use && line_rx.rec_edge))
                rxc_r <= ~rxc_r;
        end
    end

    // ----------
    // transmit path
    // ----------
    logic lpi_tx_code;

    // outside eee, txer carries no meaning and is ignored
    assign lpi_tx_code = rmii_r ? (txd[1:0] == DIB_LPI) : txer;

    // a frame is only as long as the mac holds txen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tph_r  <= 1'b0;
            tlo_r  <= 2'h0;
            tvld_r <= 1'b0;
            tnib_r <= NIB_IDLE;
            tlpi_r <= 1'b0;
            tact_r <= 1'b0;
        end else if (ce) begin
            tvld_r <= 1'b0;
            if (tx_tick) begin
                tact_r <= txen;
                tlpi_r <= eee_r & ~txen & lpi_tx_code;
                if (!txen) begin
                    tph_r <= 1'b0;
                end else if (!rmii_r) begin
                    tvld_r <= 1'b1;
                    tnib_r <= txd;
                end else if (!tph_r) begin
                    tph_r <= 1'b1;
                    tlo_r <= txd[1:0];
                end else begin
                    tph_r  <= 1'b0;
                    tvld_r <= 1'b1;
                    tnib_r <= {txd[1:0], tlo_r};
                end
            end
        end
    end

    assign line_tx.active = tact_r;
    assign line_tx.lpi    = tlpi_r;
    assign line_tx.vld    = tvld_r;
    assign line_tx.nib    = tnib_r;

    // ----------
    // receive path
    // ----------
    logic       nib_tick, sfd_seen, dv_nxt, lpi_ind, er_nxt;
    logic [3:0] idle_nib, out_nib;

    // reduced interface: one nibble per two dibit ticks
    assign nib_tick = rx_tick & (~rmii_r | ~rph_r);
    assign sfd_seen = p_vld_r & (p_nib_r == SFD_LO)
                    & line_rx.vld & (line_rx.nib == SFD_HI);
    // one nibble of delay buys the look-ahead the 10M sfd needs
    assign dv_nxt = (spd100_r | rmii_r) ? p_vld_r
                  : (rxdv_r ? p_vld_r : sfd_seen);
    // in reduced mode, under carrier the lpi code gives way to 00 until decoding starts
    assign lpi_ind  = eee_r & line_rx.lpi & ~(rmii_r & line_rx.carrier);
    assign idle_nib = !lpi_ind ? NIB_IDLE : (rmii_r ? NIB_LPI2 : NIB_LPI);
    assign out_nib  = dv_nxt ? p_nib_r : idle_nib;
    assign er_nxt   = dv_nxt ? p_err_r : lpi_ind;

    // rxdv, rxer and rxd registers move only on receive clock ticks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rph_r   <= 1'b0;
            p_vld_r <= 1'b0;
            p_err_r <= 1'b0;
            p_nib_r <= NIB_IDLE;
            rxdv_r  <= 1'b0;
            rxer_r  <= 1'b0;
            rxd_r   <= NIB_IDLE;
            rhi_r   <= 2'h0;
        end else if (ce) begin
            if (rx_tick)
                rph_r <= rmii_r & ~rph_r;
            if (nib_tick) begin
                p_vld_r <= line_rx.vld;
                p_err_r <= line_rx.err;
                p_nib_r <= line_rx.nib;
                rxdv_r  <= dv_nxt;
                rxer_r  <= er_nxt;
                rhi_r   <= out_nib[3:2];
                rxd_r   <= rmii_r ? {2'h0, out_nib[1:0]} : out_nib;
            end else if (rx_tick) begin
                rxd_r <= {2'h0, rhi_r};
            end
        end
    end

    // ----------
    // carrier sense and collision
    // ----------
    logic crs_set, crs_clr;

    assign crs_set = line_rx.sos;
    assign crs_clr = spd100_r ? (line_rx.eos | line_rx.idle) : line_rx.eos;

    // a start arriving with an end still wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            crs_r <= 1'b0;
        else if (ce)
            crs_r <= crs_set | (crs_r & ~crs_clr);
    end

    // crs_dv rises straight from the carrier detector, not on a tick
    assign phy_rxdv = rmii_r ? (line_rx.carrier | rxdv_r) : rxdv_r;
    assign phy_rxd  = rxd_r;
    assign phy_rxer = rxer_r;
    assign phy_crs  = crs_r & ~rmii_r;
    // gated straight from activity so the mac sees it without clock delay
    assign phy_col  = hdx_r & ~rmii_r & tact_r & (crs_r | line_rx.carrier);

endmodule : mpi_phy_data_if

// File: testbench/mpi_phy_data_if_sva.sv
// port checker of the phy data interface
`timescale 1ns/1ns
module mpi_phy_data_if_sva (
    // clock and reset
    input wire logic                     pclk,
    input wire logic                     presetn,
    // apb answer
    input wire logic                     psel,
    input wire logic                     penable,
    input wire logic                     pslverr,
    // straps and pins
    input wire logic [2:0]               cfg_strap,
    input wire logic                     ref_clk_out,
    input wire logic                     ref_clk_oe_n,
    input wire logic                     phy_txc,
    input wire logic                     phy_rxc,
    input wire logic                     phy_rxdv,
    input wire logic [3:0]               phy_rxd,
    input wire logic                     phy_crs,
    input wire logic                     phy_col,
    // line side
    input wire mpi_pkg::mpi_line_rx_type line_rx
);
    import mpi_pkg::*;
    logic mii_w;

    // straps change only while reset is held, so they stand for the captured mode
    assign mii_w = (cfg_strap != STRAP_RMII);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ----------
    // reference clock
    // ----------
    // one reference period after a rise: high two cycles, low three
    sequence ref_cycle_s;
        ref_clk_out ##1 !ref_clk_out [*3] ##1 ref_clk_out;
    endsequence
    ref_period_a: assert property (disable iff (!presetn || ref_clk_oe_n) $rose(ref_clk_out) |=> ref_cycle_s)
        else $error("reference clock period wrong");
    ref_off_a: assert property (ref_clk_oe_n && $past(ref_clk_oe_n) |-> !ref_clk_out)
        else $error("reference clock driven while released");

    // ----------
    // nibble clocks and receive pins
    // ----------
    // half periods are 5 cycles at 100M and 50 at 10M, never shorter
    txc_high_a: assert property (disable iff (!presetn || !mii_w) $rose(phy_txc) |=> phy_txc [*4])
        else $error("transmit clock high phase short");
    txc_low_a: assert property (disable iff (!presetn || !mii_w) $fell(phy_txc) |=> !phy_txc [*4])
        else $error("transmit clock low phase short");
    txc_runs_a: assert property (disable iff (!presetn || !mii_w) !phy_txc |-> ##[1:110] phy_txc)
        else $error("transmit clock stopped");
    rxc_runs_a: assert property (disable iff (!presetn || !mii_w) !phy_rxc |-> ##[1:110] phy_rxc)
        else $error("receive clock stopped");
    rx_idle_a: assert property (!phy_rxdv |-> phy_rxd == NIB_IDLE || phy_rxd == NIB_LPI)
        else $error("receive data not idle code");
    col_cause_a: assert property (phy_col |-> phy_crs || line_rx.carrier)
        else $error("collision without receive activity");
    rmii_quiet_a: assert property (!mii_w |-> !phy_txc && !phy_rxc && !phy_crs && !phy_col && phy_rxd[3:2] == 2'h0)
        else $error("nibble pins active in reduced mode");
    slverr_phase_a: assert property (pslverr |-> psel && penable)
        else $error("slave error outside access phase");
endmodule : mpi_phy_data_if_sva

bind mpi_phy_data_if mpi_phy_data_if_sva u_sva (.pclk, .presetn, .psel, .penable, .pslverr, .cfg_strap,
    .ref_clk_out, .ref_clk_oe_n, .phy_txc, .phy_rxc, .phy_rxdv, .phy_rxd, .phy_crs, .phy_col, .line_rx);

// File: testbench/mpi_mac_model.sv
// mac transmit model sending frames on the phy transmit or reference clock
`timescale 1ns/1ns
module mpi_mac_model (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // bench control
    input  wire logic       go,
    input  wire logic       eee,
    input  wire logic [7:0] nibs,
    input  wire logic       rmii,
    output logic            busy,
    // transmit pins
    input  wire logic       phy_txc,
    output logic            phy_txen,
    output logic [3:0]      phy_txd,
    output logic            phy_txer
);
    import mpi_pkg::*;
    logic       txc_q_r;
    logic [7:0] left_r;
    logic [7:0] pos_w;
    logic [3:0] nib_w;
    logic       hi_r;
    logic [3:0] out_w;

    // fifteen preamble 5s, then d, then a counting payload
    assign pos_w = nibs - left_r;
    assign nib_w = (pos_w < 8'h0F) ? SFD_LO : (pos_w == 8'h0F) ? SFD_HI : pos_w[3:0];
    assign busy  = (left_r != 8'h00) | phy_txen;
    // reduced mode sends each nibble as two dibits, low pair first
    assign out_w = rmii ? {2'h0, hi_r ? nib_w[3:2] : nib_w[1:0]} : nib_w;

    // pins move one cycle after a seen txc rise, far from the next rise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txc_q_r  <= 1'b0;
            hi_r     <= 1'b0;
            left_r   <= 8'h00;
            phy_txen <= 1'b0;
            phy_txd  <= NIB_IDLE;
            phy_txer <= 1'b0;
        end else begin
            txc_q_r <= phy_txc;
            if (go) begin
                left_r <= nibs;
            end else if (phy_txc && !txc_q_r) begin
                phy_txen <= (left_r != 8'h00);
                phy_txd  <= (left_r != 8'h00) ? out_w : (eee ? NIB_LPI : NIB_IDLE);
                phy_txer <= (left_r == 8'h00) && eee;
                if (left_r != 8'h00) begin
                    hi_r <= rmii & ~hi_r;
                    if (!rmii || hi_r) left_r <= left_r - 8'h01;
                end
            end
        end
    end
endmodule : mpi_mac_model

// File: testbench/test_mpi_phy_data_if.sv
// self-checking bench of the phy data interface
`timescale 1ns/1ns
module test_mpi_phy_data_if;
    import mpi_pkg::*;
    localparam logic [11:0] A_PHY = {4'h0, IDX_PHYCTL, 2'h0};
    localparam logic [11:0] A_LNK = {4'h0, IDX_LNKCTL, 2'h0};
    localparam logic [11:0] A_STA = {4'h0, IDX_STAT, 2'h0};
    logic pclk = 1'b0, presetn, psel, penable, pwrite, pready, pslverr, crystal_input, ref_clk_out, ref_clk_oe_n;
    logic phy_txc, phy_txen, phy_txer, phy_rxc, phy_rxdv, phy_rxer, phy_crs, phy_col, go, eee, busy, mon_en, seen_err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d;
    logic [2:0] cfg_strap;
    logic [3:0] phy_txd, phy_rxd;
    logic [7:0] nibs;
    logic e;
    mpi_line_rx_type lrx;
    mpi_line_tx_type ltx;
    logic [3:0] rq[$];
    logic [3:0] tq[$];
    int n_mismatch = 0, total_checks = 0, cyc = 0;

    mpi_phy_data_if dut (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .cfg_strap, .crystal_input, .ref_clk_out, .ref_clk_oe_n, .phy_txc, .phy_txen, .phy_txd, .phy_txer,
        .phy_rxc, .phy_rxdv, .phy_rxd, .phy_rxer, .phy_crs, .phy_col, .line_rx(lrx), .line_tx(ltx));
    mpi_mac_model mac (.pclk, .presetn, .go, .eee, .nibs, .busy, .rmii(cfg_strap == STRAP_RMII),
        .phy_txc(phy_txc | ref_clk_out), .phy_txen, .phy_txd, .phy_txer);

    // ----------
    // clocks, watchdog, monitors
    // ----------
    // the outside reference has its own phase so edges never line up with pclk
    always #2 pclk = ~pclk;
    initial begin
        crystal_input = 1'b0;
        #7;
        forever #80 crystal_input = ~crystal_input;
    end
    always @(posedge pclk) begin
        cyc = cyc + 1;
        if (cyc == 40000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    // receive pins are read mid period, away from their update edge
    always @(negedge phy_rxc) begin
        if (mon_en && phy_rxdv === 1'b1) rq.push_back(phy_rxd);
        if (mon_en && phy_rxer === 1'b1) seen_err = 1'b1;
    end
    always @(posedge pclk) if (ltx.vld === 1'b1) tq.push_back(ltx.nib);

    // ----------
    // helpers
    // ----------
    function automatic logic [3:0] fnib(input int k);
        return (k < 15) ? SFD_LO : (k == 15) ? SFD_HI : 4'(k);
    endfunction : fnib
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic chk1(input string name, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %b seen %b", name, exp, got);
        end
    endtask : chk1
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic do_reset(input logic [2:0] s);
        presetn <= 1'b0;
        cfg_strap <= s;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask : do_reset
    // sends the 24 nibble counting frame and checks what reached the line side
    task automatic tx_frame(input logic col_exp);
        tq.delete();
        nibs <= 8'h18;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        while (tq.size() < 8) @(posedge pclk);
        chk1("col", col_exp, phy_col);
        while (busy !== 1'b0) @(posedge pclk);
        repeat (20) @(posedge pclk);
        chk("tx count", 32'd24, tq.size());
        chk("tx sfd", 32'(SFD_HI), 32'(tq[15]));
        chk("tx last", 32'(fnib(23)), 32'(tq[23]));
    endtask : tx_frame

    // ----------
    // scenarios
    // ----------
    task automatic t_regs();
        apb(1'b0, A_PHY, 32'h0);
        chk("phyctl reset", 32'h0000_0000, d);
        apb(1'b0, A_LNK, 32'h0);
        chk("lnkctl reset", 32'h0000_0001, d);
        apb(1'b1, A_PHY, 32'h0000_0080);
        apb(1'b0, A_PHY, 32'h0);
        chk("phyctl bit7", 32'h0000_0080, d);
        apb(1'b1, A_PHY, 32'h0);
        apb(1'b0, A_STA, 32'h0);
        chk1("stat mode", 1'b0, d[6]);
        apb(1'b0, 12'hFF0, 32'h0);
        chk1("unmapped err", 1'b1, e);
        chk("unmapped data", 32'h0000_0000, d);
        $display("test regs done");
    endtask : t_regs
    // a 24 nibble frame with one coded error; 10M keeps only the sfd onwards
    task automatic t_rx(input logic spd, input int n_exp);
        apb(1'b1, A_LNK, {31'h0, spd});
        rq.delete();
        seen_err = 1'b0;
        mon_en = 1'b1;
        lrx.carrier <= 1'b1;
        for (int k = 0; k < 24; k++) begin
            @(posedge phy_rxc);
            lrx.vld <= 1'b1;
            lrx.nib <= fnib(k);
            lrx.err <= (k == 20);
            lrx.sos <= (k == 0);
            @(posedge pclk);
            lrx.sos <= 1'b0;
            if (k == 12) chk1("crs mid", 1'b1, phy_crs);
        end
        @(posedge phy_rxc);
        lrx <= '{link: 1'b1, eos: spd ? 1'b0 : 1'b1, idle: spd, default: '0};
        @(posedge pclk);
        lrx <= '{link: 1'b1, default: '0};
        repeat (3) @(posedge phy_rxc);
        mon_en = 1'b0;
        chk1("crs end", 1'b0, phy_crs);
        chk("rx count", n_exp, rq.size());
        chk("rx first", 32'(fnib(24 - n_exp)), 32'(rq[0]));
        chk("rx last", 32'(fnib(23)), 32'(rq[$]));
        chk1("rx err", 1'b1, seen_err);
        apb(1'b1, A_LNK, 32'h0000_0001);
        $display("test rx done");
    endtask : t_rx
    task automatic t_tx();
        apb(1'b1, A_LNK, 32'h0000_0005);
        lrx.carrier <= 1'b1;
        tx_frame(1'b1);
        chk1("col idle", 1'b0, phy_col);
        lrx.carrier <= 1'b0;
        apb(1'b1, A_LNK, 32'h0000_0001);
        $display("test tx done");
    endtask : t_tx
    task automatic t_lpi(input logic on);
        apb(1'b1, A_LNK, {30'h0, on, 1'b1});
        eee <= on;
        lrx.lpi <= on;
        repeat (4) @(posedge phy_txc);
        chk("rxd idle", 32'(on ? NIB_LPI : NIB_IDLE), 32'(phy_rxd));
        chk1("rxer lpi", on, phy_rxer);
        chk1("tx lpi", on, ltx.lpi);
        $display("test lpi done");
    endtask : t_lpi
    task automatic t_rmii();
        int r;
        r = 0;
        chk1("ref oe", 1'b0, ref_clk_oe_n);
        repeat (50) @(posedge pclk) r += int'(ref_clk_out);
        chk("ref high", 32'd20, r);
        lrx.carrier <= 1'b1;
        @(posedge pclk);
        #1;
        chk1("crs_dv up", 1'b1, phy_rxdv);
        chk("rxd undecoded", 32'h0, 32'(phy_rxd));
        @(posedge pclk);
        lrx.carrier <= 1'b0;
        repeat (3) @(posedge pclk);
        chk1("crs_dv down", 1'b0, phy_rxdv);
        tx_frame(1'b0);
        apb(1'b1, A_LNK, 32'h0000_0003);
        lrx.lpi <= 1'b1;
        repeat (20) @(posedge pclk);
        chk("rmii lpi", 32'h1, 32'(phy_rxd));
        lrx.lpi <= 1'b0;
        apb(1'b0, A_STA, 32'h0);
        chk1("stat mode", 1'b1, d[6]);
        apb(1'b1, A_PHY, 32'h0000_0080);
        repeat (2) @(posedge pclk);
        chk1("ref released", 1'b1, ref_clk_oe_n);
        chk1("ref quiet", 1'b0, ref_clk_out);
        $display("test rmii done");
    endtask : t_rmii

    task end_of_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test

    // ----------
    // main sequence
    // ----------
    initial begin
        {presetn, psel, penable, pwrite, go, eee, mon_en, seen_err} = '0;
        {paddr, pwdata, nibs} = '0;
        cfg_strap = 3'h0;
        lrx = '{link: 1'b1, default: '0};
        do_reset(3'h0);
        t_regs();
        t_rx(1'b1, 24);
        t_rx(1'b0, 10);
        t_tx();
        t_lpi(1'b1);
        t_lpi(1'b0);
        do_reset(STRAP_RMII);
        t_rmii();
        end_of_test();
    end
endmodule : test_mpi_phy_data_if
